// *** rwc_reset_wakeup_control.v ***
// Operation
// - reset on power-on, pin low, watchdog time-out
// - hold core reset one start-up period
// - oscillator on, program counter zero in reset
// - all port pins inputs during reset
// - clear watchdog count and prescaler on reset
// - power-on clears status upper three bits
// - retained registers keep values across reset
// - control registers load zeros, pull/portB ones
// - sleep enters power-down, clears running watchdog
// - wake delay 10us RC, 800us crystal
// - wake on enabled peripheral events
// - pin or watchdog wake does full reset
// - event wake resumes or branches to vector
// - watchdog enabled blocks event wake-ups
// - spi slave reception wakes when enabled
// - tick counter halts while sleeping
`include "rwc_map.vh"
module rwc_reset_wakeup_control #(
   parameter OST_CYCLES = `RWC_OST_MS * 1000 * 1000 / 10,
   parameter WAKE_RC_CYCLES = `RWC_WAKE_RC_US * `RWC_CLK_MHZ,
   parameter WAKE_XTAL_CYCLES = `RWC_WAKE_XTAL_US * `RWC_CLK_MHZ,
   parameter CW = 24
) (
   input wire clk,
   input wire sys_rst,
   input wire clkEn,
   input wire powerOnPulse,
   input wire extResetN,
   input wire watchdogTick,
   input wire watchdogEnable,
   input wire crystalMode,
   input wire sleepInstr,
   input wire globalIrqOnInstr,
   input wire globalIrqOffInstr,
   input wire watchdogClearInstr,
   input wire [`RWC_NSRC-1:0] wakeEnable,
   input wire [`RWC_NSRC-1:0] wakeEventRaw,
   input wire spiSlaveMode,
   input wire [`RWC_PC_W-1:0] pcNext,
   input wire pcLoad,
   input wire [7:0] statusWrData,
   input wire statusWr,
   input wire [7:0] ctrlWrData,
   input wire [2:0] ctrlWrSel,
   input wire ctrlWr,
   input wire [7:0] retainedWrData,
   input wire [1:0] retainedWrSel,
   input wire retainedWr,
   input wire [15:0] watchdogTimeoutCount,
   output reg coreResetHold,
   output reg oscEnable,
   output reg [`RWC_PC_W-1:0] programCounter,
   output reg portsAsInputs,
   output reg [7:0] statusFlags,
   output reg [7:0] retainedRegOne,
   output reg [7:0] retainedRegTwo,
   output reg [7:0] retainedRegThree,
   output reg [7:0] timerOption,
   output reg [7:0] watchdogCtrl,
   output reg [7:0] portCfgB,
   output reg [7:0] opendrainCtrl,
   output reg [7:0] pullhighCtrl,
   output reg [7:0] irqMaskTwo,
   output reg [7:0] irqMaskOne,
   output reg [15:0] watchdogCount,
   output reg [7:0] watchdogPrescale,
   output reg sleeping,
   output reg tickCounterRun,
   output reg branchToVector,
   output reg [`RWC_NSRC-1:0] vectorSource,
   output reg resumeNext
);
   localparam ST_RESET = 4'b0001;
   localparam ST_RUN = 4'b0010;
   localparam ST_SLEEP = 4'b0100;
   localparam ST_WAKE = 4'b1000;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg globalIrq_reg;
   reg irqAtSleep_reg;
   reg wdAtSleep_reg;
   reg [`RWC_NSRC-1:0] wakeSrc_reg;
   reg [`RWC_NSRC-1:0] evPrev_reg;
   reg [`RWC_NSRC-1:0] srcMask;
   reg porPending_reg;
   reg wdtTimeout;
   reg loadDelay;
   reg [CW-1:0] delayValue;
   wire extResetSyncN;
   wire [`RWC_NSRC-1:0] eventSync;
   wire delayBusy;
   wire delayDone;
   wire [`RWC_NSRC-1:0] eventEdge;
   wire [`RWC_NSRC-1:0] wakeHit;
   wire resetRequest;

   rwc_sync2 #(.W(1), .INIT(1'b1)) uSyncReset (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .pinIn(extResetN),
      .syncOut(extResetSyncN)
   );

   rwc_sync2 #(.W(`RWC_NSRC), .INIT({`RWC_NSRC{1'b0}})) uSyncEvents (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .pinIn(wakeEventRaw),
      .syncOut(eventSync)
   );

   rwc_delay_counter #(.W(CW)) uDelay (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .load(loadDelay),
      .loadValue(delayValue),
      .busy(delayBusy),
      .done(delayDone)
   );

   // events are change-type: any toggle of the synchronised level counts
   assign eventEdge = eventSync ^ evPrev_reg;
   // spi wake only as slave; watchdog on at sleep masks every event
   always @* begin
      srcMask = {`RWC_NSRC{1'b1}};
      srcMask[`RWC_SRC_SPI] = spiSlaveMode;
   end
   assign wakeHit = eventEdge & wakeEnable & srcMask & {`RWC_NSRC{~wdAtSleep_reg}};

   always @* begin
      wdtTimeout = watchdogEnable && watchdogTick && (watchdogCount >= watchdogTimeoutCount);
   end

   // pin held low keeps restarting the start-up period
   assign resetRequest = powerOnPulse || !extResetSyncN || wdtTimeout;

   always @* begin
      state_next = state_reg;
      loadDelay = 1'b0;
      delayValue = OST_CYCLES[CW-1:0];
      if (resetRequest) begin
         state_next = ST_RESET;
         loadDelay = 1'b1;
      end else begin
         case (state_reg)
            ST_RESET: begin
               if (delayDone) state_next = ST_RUN;
            end
            ST_RUN: begin
               if (sleepInstr) state_next = ST_SLEEP;
            end
            ST_SLEEP: begin
               if (|wakeHit) begin
                  state_next = ST_WAKE;
                  loadDelay = 1'b1;
                  delayValue = crystalMode ? WAKE_XTAL_CYCLES[CW-1:0] : WAKE_RC_CYCLES[CW-1:0];
               end
            end
            ST_WAKE: begin
               if (delayDone) state_next = ST_RUN;
            end
            default: state_next = ST_RESET;
         endcase
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_RESET;
         porPending_reg <= 1'b1;
         globalIrq_reg <= 1'b0;
         irqAtSleep_reg <= 1'b0;
         wdAtSleep_reg <= 1'b0;
         wakeSrc_reg <= {`RWC_NSRC{1'b0}};
         evPrev_reg <= {`RWC_NSRC{1'b0}};
         coreResetHold <= 1'b1;
         oscEnable <= 1'b1;
         programCounter <= `RWC_PC_RESET;
         portsAsInputs <= 1'b1;
         statusFlags <= `RWC_ZERO8;
         retainedRegOne <= `RWC_ZERO8;
         retainedRegTwo <= `RWC_ZERO8;
         retainedRegThree <= `RWC_ZERO8;
         timerOption <= `RWC_ZERO8;
         watchdogCtrl <= `RWC_ZERO8;
         portCfgB <= `RWC_ONES8;
         opendrainCtrl <= `RWC_ZERO8;
         pullhighCtrl <= `RWC_ONES8;
         irqMaskTwo <= `RWC_ZERO8;
         irqMaskOne <= `RWC_ZERO8;
         watchdogCount <= 16'h0000;
         watchdogPrescale <= `RWC_ZERO8;
         sleeping <= 1'b0;
         tickCounterRun <= 1'b0;
         branchToVector <= 1'b0;
         vectorSource <= {`RWC_NSRC{1'b0}};
         resumeNext <= 1'b0;
      end else if (clkEn) begin
         state_reg <= state_next;
         evPrev_reg <= eventSync;
         branchToVector <= 1'b0;
         resumeNext <= 1'b0;
         sleeping <= (state_next == ST_SLEEP) || (state_next == ST_WAKE);
         tickCounterRun <= (state_next == ST_RUN);
         coreResetHold <= (state_next == ST_RESET);
         oscEnable <= (state_next != ST_SLEEP);
         if (globalIrqOnInstr) globalIrq_reg <= 1'b1;
         else if (globalIrqOffInstr) globalIrq_reg <= 1'b0;

         // watchdog: counts watchdogTick, prescaler only held at zero, cleared by instruction, sleep or reset
         if (resetRequest || state_reg == ST_RESET) begin
            watchdogCount <= 16'h0000;
            watchdogPrescale <= `RWC_ZERO8;
         end else if (watchdogClearInstr || (state_reg == ST_RUN && sleepInstr)) begin
            watchdogCount <= 16'h0000;
            watchdogPrescale <= `RWC_ZERO8;
         end else if (watchdogEnable && watchdogTick) begin
            watchdogCount <= watchdogCount + 16'h0001;
         end

         if (resetRequest) begin
            programCounter <= `RWC_PC_RESET;
            portsAsInputs <= 1'b1;
            timerOption <= `RWC_ZERO8;
            watchdogCtrl <= `RWC_ZERO8;
            opendrainCtrl <= `RWC_ZERO8;
            irqMaskTwo <= `RWC_ZERO8;
            irqMaskOne <= `RWC_ZERO8;
            portCfgB <= `RWC_ONES8;
            pullhighCtrl <= `RWC_ONES8;
            globalIrq_reg <= 1'b0;
            // retained registers deliberately untouched
            if (powerOnPulse || porPending_reg) begin
               statusFlags <= statusFlags & `RWC_STATUS_UPPER_CLR;
               porPending_reg <= 1'b0;
            end
            // record cause of a reset that woke a sleeping core
            if (state_reg == ST_SLEEP || state_reg == ST_WAKE) begin
               statusFlags[`RWC_FLAG_TIMEOUT] <= ~wdtTimeout;
               statusFlags[`RWC_FLAG_PWRDOWN] <= 1'b0;
            end else if (wdtTimeout) begin
               statusFlags[`RWC_FLAG_TIMEOUT] <= 1'b0;
            end
         end else begin
            if (state_reg == ST_RESET && delayDone) portsAsInputs <= 1'b0;
            if (state_reg == ST_RUN && pcLoad) programCounter <= pcNext;
            if (statusWr) statusFlags <= statusWrData;
            if (state_reg == ST_RUN && sleepInstr) begin
               statusFlags[`RWC_FLAG_PWRDOWN] <= 1'b0;
               statusFlags[`RWC_FLAG_TIMEOUT] <= 1'b1;
               irqAtSleep_reg <= globalIrq_reg;
               wdAtSleep_reg <= watchdogEnable;
            end
            if (retainedWr) begin
               if (retainedWrSel == 2'b00) retainedRegOne <= retainedWrData;
               else if (retainedWrSel == 2'b01) retainedRegTwo <= retainedWrData;
               else retainedRegThree <= retainedWrData;
            end
            if (ctrlWr) begin
               if (ctrlWrSel == 3'h0) timerOption <= ctrlWrData;
               else if (ctrlWrSel == 3'h1) watchdogCtrl <= ctrlWrData;
               else if (ctrlWrSel == 3'h2) portCfgB <= ctrlWrData;
               else if (ctrlWrSel == 3'h3) opendrainCtrl <= ctrlWrData;
               else if (ctrlWrSel == 3'h4) pullhighCtrl <= ctrlWrData;
               else if (ctrlWrSel == 3'h5) irqMaskTwo <= ctrlWrData;
               else if (ctrlWrSel == 3'h6) irqMaskOne <= ctrlWrData;
            end
            if (state_reg == ST_SLEEP && |wakeHit) wakeSrc_reg <= wakeHit;
            if (state_reg == ST_WAKE && delayDone) begin
               vectorSource <= wakeSrc_reg;
               branchToVector <= irqAtSleep_reg;
               resumeNext <= ~irqAtSleep_reg;
               wdAtSleep_reg <= 1'b0;
            end
         end
      end
   end
endmodule // rwc_reset_wakeup_control

// *** rwc_map.vh ***
`ifndef RWC_MAP_VH
`define RWC_MAP_VH
// widths and reset values
`define RWC_PC_W 11
`define RWC_PC_RESET 11'h000
`define RWC_ZERO8 8'h00
`define RWC_ONES8 8'hFF
`define RWC_STATUS_UPPER_CLR 8'h1F
// status flag positions
`define RWC_FLAG_TIMEOUT 4
`define RWC_FLAG_PWRDOWN 3
// wake source index positions
`define RWC_SRC_PORT 0
`define RWC_SRC_CMP 1
`define RWC_SRC_ADC 2
`define RWC_SRC_EXT 3
`define RWC_SRC_SPI 4
`define RWC_NSRC 5
// timing, printed units
`define RWC_CLK_MHZ 100
`define RWC_OST_MS 18
`define RWC_WAKE_RC_US 10
`define RWC_WAKE_XTAL_US 800
`endif

// *** rwc_delay_counter.v ***
// loadable down-counter; done is a one-cycle pulse when the count is at one or less, without stepping to zero
module rwc_delay_counter #(
   parameter W = 24
) (
   input wire clk,
   input wire sys_rst,
   input wire clkEn,
   input wire load,
   input wire [W-1:0] loadValue,
   output wire busy,
   output reg done
);
   reg [W-1:0] count_reg;
   reg run_reg;
   assign busy = run_reg;
   always @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= {W{1'b0}};
         run_reg <= 1'b0;
         done <= 1'b0;
      end else if (clkEn) begin
         done <= 1'b0;
         if (load) begin
            count_reg <= loadValue;
            run_reg <= 1'b1;
         end else if (run_reg) begin
            if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
               run_reg <= 1'b0;
               done <= 1'b1;
            end else begin
               count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // rwc_delay_counter

// *** rwc_sync2.v ***
// two-flop synchroniser for a bus of pin levels
module rwc_sync2 #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clk,
   input wire sys_rst,
   input wire clkEn,
   input wire [W-1:0] pinIn,
   output reg [W-1:0] syncOut
);
   reg [W-1:0] stage1_reg;
   always @(posedge clk) begin
      if (sys_rst) begin
         stage1_reg <= INIT;
         syncOut <= INIT;
      end else if (clkEn) begin
         stage1_reg <= pinIn;
         syncOut <= stage1_reg;
      end
   end
endmodule // rwc_sync2

// *** rwc_reset_wakeup_control_chk.sv ***
module rwc_reset_wakeup_control_chk #(
   parameter OST_CYCLES = 50
) (
   input logic clk,
   input logic sys_rst,
   input logic powerOnPulse,
   input logic statusWr,
   input logic coreResetHold,
   input logic oscEnable,
   input logic [10:0] programCounter,
   input logic portsAsInputs,
   input logic [7:0] statusFlags,
   input logic [7:0] retainedRegOne,
   input logic [7:0] timerOption,
   input logic [7:0] portCfgB,
   input logic [7:0] pullhighCtrl,
   input logic [15:0] watchdogCount,
   input logic sleeping,
   input logic tickCounterRun,
   input logic branchToVector,
   input logic resumeNext
);
   logic [31:0] holdCnt_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // counts the length of the current hold so its release can be bounded
   always_ff @(posedge clk) begin
      if (sys_rst || !coreResetHold) holdCnt_reg <= 32'h0;
      else holdCnt_reg <= holdCnt_reg + 32'h1;
   end
   property p_hold_len;
      $fell(coreResetHold) |-> holdCnt_reg >= OST_CYCLES;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold released early");
   property p_pc_osc;
      coreResetHold && $past(coreResetHold) |-> programCounter == 11'h000 && oscEnable;
   endproperty
   a_pc_osc: assert property (p_pc_osc) else $error("pc or osc wrong in hold");
   property p_ports;
      coreResetHold && $past(coreResetHold) |-> portsAsInputs;
   endproperty
   a_ports: assert property (p_ports) else $error("ports not inputs");
   property p_wd_clr;
      $rose(coreResetHold) |-> ##[0:2] watchdogCount == 16'h0000;
   endproperty
   a_wd_clr: assert property (p_wd_clr) else $error("watchdog not cleared");
   property p_status_keep;
      $rose(coreResetHold) && !powerOnPulse && !$past(powerOnPulse) && !$past(statusWr)
         |-> statusFlags[7:5] == $past(statusFlags[7:5]);
   endproperty
   a_status_keep: assert property (p_status_keep) else $error("status upper lost");
   property p_retain;
      $rose(coreResetHold) |-> $stable(retainedRegOne);
   endproperty
   a_retain: assert property (p_retain) else $error("retained lost");
   property p_defaults;
      coreResetHold && $past(coreResetHold) |-> timerOption == 8'h00 && portCfgB == 8'hFF && pullhighCtrl == 8'hFF;
   endproperty
   a_defaults: assert property (p_defaults) else $error("control defaults wrong");
   property p_sleep_entry;
      $rose(sleeping) |-> !oscEnable && watchdogCount == 16'h0000;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
   property p_tick_stop;
      sleeping |-> !tickCounterRun;
   endproperty
   a_tick_stop: assert property (p_tick_stop) else $error("tick counter runs asleep");
   property p_wake_pulse;
      branchToVector || resumeNext |-> $fell(sleeping) && !(branchToVector && resumeNext);
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("stray wake pulse");
endmodule // rwc_reset_wakeup_control_chk
bind rwc_reset_wakeup_control rwc_reset_wakeup_control_chk #(.OST_CYCLES(OST_CYCLES)) u_chk (.*);

// *** rwc_event_source.sv ***
module rwc_event_source (
   input logic clk,
   input logic fire,
   input logic [2:0] which,
   input logic pinLow,
   output logic extResetN,
   output logic [4:0] wakeEventRaw
);
   timeunit 1ns;
   timeprecision 1ns;
   initial extResetN = 1'h1;
   initial wakeEventRaw = 5'h00;
   // which of 5 toggles every source at once; sampled on the rising edge so
   // the bench's falling-edge requests are settled and never raced
   always @(posedge clk) begin
      if (fire) wakeEventRaw <= wakeEventRaw ^ ((which == 3'h5) ? 5'h1F : (5'h01 << which));
      extResetN <= !pinLow;
   end
endmodule // rwc_event_source

// *** rwc_reset_wakeup_control_tb.sv ***
module rwc_reset_wakeup_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam OST = 50;
   localparam RC = 5;
   localparam XT = 20;
   logic clk = 1'h0, sys_rst = 1'h1, powerOnPulse = 1'h0, watchdogTick = 1'h0, watchdogEnable = 1'h0;
   logic crystalMode = 1'h0, sleepInstr = 1'h0, globalIrqOnInstr = 1'h0, globalIrqOffInstr = 1'h0;
   logic spiSlaveMode = 1'h1, pcLoad = 1'h0, statusWr = 1'h0, ctrlWr = 1'h0, retainedWr = 1'h0;
   logic fire = 1'h0, pinLow = 1'h0, extResetN;
   logic [2:0] which = 3'h0, ctrlWrSel = 3'h0;
   logic [1:0] retainedWrSel = 2'h0;
   logic [4:0] wakeEnable = 5'h00, wakeEventRaw, vectorSource;
   logic [10:0] pcNext = 11'h000, programCounter;
   logic [7:0] statusWrData = 8'h00, ctrlWrData = 8'h00, retainedWrData = 8'h00;
   logic coreResetHold, oscEnable, portsAsInputs, sleeping, tickCounterRun, branchToVector, resumeNext;
   logic [7:0] statusFlags, retainedRegOne, retainedRegTwo, retainedRegThree, timerOption, watchdogCtrl;
   logic [7:0] portCfgB, opendrainCtrl, pullhighCtrl, irqMaskTwo, irqMaskOne, watchdogPrescale;
   logic [15:0] watchdogCount;
   logic [31:0] seed = 32'hA8F88AD2;
   int n_fail = 0, n_tests = 0;
   rwc_reset_wakeup_control #(.OST_CYCLES(OST), .WAKE_RC_CYCLES(RC), .WAKE_XTAL_CYCLES(XT)) u_rwc_reset_wakeup_control (
      .clkEn(1'h1), .watchdogClearInstr(1'h0), .watchdogTimeoutCount(16'h0003), .*);
   rwc_event_source u_rwc_event_source (.clk(clk), .fire(fire), .which(which), .pinLow(pinLow),
      .extResetN(extResetN), .wakeEventRaw(wakeEventRaw));
   always #5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] ctrlDefault(int s);
      return (s == 2 || s == 4) ? 8'hFF : 8'h00;
   endfunction
   function automatic logic [7:0] ctrlSeen(int s);
      case (s)
         0: return timerOption;
         1: return watchdogCtrl;
         2: return portCfgB;
         3: return opendrainCtrl;
         4: return pullhighCtrl;
         5: return irqMaskTwo;
         default: return irqMaskOne;
      endcase
   endfunction
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
   endtask
   // bounded so a stuck hold cannot hang the run
   task automatic waitRelease(output int c);
      c = 0;
      while (coreResetHold !== 1'h0 && c < 5000) begin
         tick(1);
         c++;
      end
   endtask
   task automatic tally_and_finish();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      int c;
      logic [31:0] r;
      logic [7:0] r1, st;
      tick(5);
      sys_rst = 1'h0;
      for (int s = 0; s < 7; s++) check("ctrl", ctrlSeen(s), ctrlDefault(s));
      pulse(powerOnPulse);
      waitRelease(c);
      check("hold len", c >= OST && c <= OST + 4, 1);
      check("status upper", statusFlags[7:5], 0);
      $display("test power-on done");
      pcNext = rnd();
      pulse(pcLoad);
      st = rnd();
      statusWrData = st;
      pulse(statusWr);
      ctrlWr = 1'h1;
      for (int s = 0; s < 7; s++) begin
         ctrlWrSel = s;
         ctrlWrData = rnd();
         tick(1);
      end
      ctrlWr = 1'h0;
      r1 = rnd();
      retainedWrData = r1;
      pulse(retainedWr);
      pinLow = 1'h1;
      tick(4);
      pinLow = 1'h0;
      tick(3);
      check("pin reset", coreResetHold, 1);
      check("pc", programCounter, 0);
      check("ports", portsAsInputs, 1);
      check("wd count", watchdogCount, 0);
      for (int s = 0; s < 7; s++) check("ctrl", ctrlSeen(s), ctrlDefault(s));
      check("retained", retainedRegOne, r1);
      check("status keep", statusFlags[7:5], st[7:5]);
      waitRelease(c);
      $display("test pin reset done");
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         crystalMode = r[1];
         // each source i wakes in turn here; watchdogEnable is still off so no event is masked
         wakeEnable = 5'h01 << i;
         if (r[0]) pulse(globalIrqOnInstr);
         else pulse(globalIrqOffInstr);
         pulse(sleepInstr);
         tick(2);
         check("asleep", sleeping, 1);
         check("tick run", tickCounterRun, 0);
         which = i;
         pulse(fire);
         c = 0;
         while (branchToVector !== 1'h1 && resumeNext !== 1'h1 && c < 5000) begin
            tick(1);
            c++;
         end
         check("vector", branchToVector, r[0]);
         check("resume", resumeNext, !r[0]);
         check("source", vectorSource, 5'h01 << i);
         check("wake delay", c >= (r[1] ? XT : RC), 1);
      end
      $display("test wake sources done");
      watchdogEnable = 1'h1;
      wakeEnable = 5'h1F;
      pulse(sleepInstr);
      which = 3'h5;
      pulse(fire);
      tick(40);
      check("wd blocks", sleeping, 1);
      watchdogTick = 1'h1;
      tick(10);
      watchdogTick = 1'h0;
      watchdogEnable = 1'h0;
      check("wd reset", coreResetHold, 1);
      waitRelease(c);
      check("wd flags", statusFlags[4:3], 0);
      spiSlaveMode = 1'h0;
      wakeEnable = 5'h10;
      pulse(sleepInstr);
      which = 3'h4;
      pulse(fire);
      which = 3'h0;
      pulse(fire);
      tick(40);
      check("refused", sleeping, 1);
      pulse(pinLow);
      tick(3);
      waitRelease(c);
      check("pin flags", statusFlags[4:3], 2);
      $display("test refusals done");
      tally_and_finish();
   end
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
endmodule // rwc_reset_wakeup_control_tb
